// ===== hw/cpu_core_pkg.sv
// Shared constants and types for the CPU register file and data map
package cpu_core_pkg;
    // Register file geometry
    localparam int NUM_REGS = 32;
    localparam logic [4:0] IMM_REG_BASE = 5'h10;
    // Pointer pair low-byte registers
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    // Linear data space layout
    localparam logic [15:0] REG_END = 16'h0020;
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] SRAM_BASE = 16'h0060;
    localparam logic [15:0] SRAM_END = 16'h0260;
    localparam int SRAM_BYTES = 512;
    // Internal I/O locations
    localparam logic [5:0] IO_SP_LO = 6'h3D;
    localparam logic [5:0] IO_SP_HI = 6'h3E;
    localparam logic [5:0] IO_STATUS = 6'h3F;
    // Status bit positions and reset values
    localparam int STATUS_C = 0;
    localparam int STATUS_Z = 1;
    localparam int STATUS_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Program counter, stack pointer and vectors
    localparam int PC_W = 12;
    localparam int SP_W = 10;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [9:0] SP_RESET = 10'h000;
    localparam logic [11:0] VEC_FIRST_IRQ = 12'h001;
    localparam int NUM_IRQ = 16;
    // ALU functions
    typedef enum logic [3:0] {
        ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
        ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_EOR = 4'h6, ALU_PASS = 4'h7,
        ALU_INC = 4'h8, ALU_DEC = 4'h9, ALU_COM = 4'hA, ALU_LSR = 4'hB,
        ALU_CP = 4'hC, ALU_CPC = 4'hD, ALU_SWAP = 4'hE
    } alu_func_t;
    // Decoded operation classes
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_ALU_RR = 4'h1, OP_ALU_RK = 4'h2, OP_ALU_R = 4'h3,
        OP_LD = 4'h4, OP_ST = 4'h5, OP_IN = 4'h6, OP_OUT = 4'h7,
        OP_RJMP = 4'h8, OP_RCALL = 4'h9, OP_IJMP = 4'hA, OP_RET = 4'hB,
        OP_RETI = 4'hC, OP_LPM = 4'hD
    } op_t;
    // Data addressing modes
    typedef enum logic [2:0] {
        AM_DIRECT = 3'h0, AM_DISP = 3'h1, AM_IND = 3'h2, AM_PREDEC = 3'h3, AM_POSTINC = 3'h4
    } addr_mode_t;
    // Pointer selection
    typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} ptr_sel_t;
    // Execute states, Gray along run -> wait -> run
    typedef enum logic [1:0] {ST_RUN = 2'b00, ST_WAIT_IO = 2'b01, ST_WAIT_CONST = 2'b10} state_t;
endpackage

// ===== hw/cpu_alu8.sv
// Eight-bit arithmetic, logic and bit-function unit
`timescale 1ns/1ps
module cpu_alu8 (
    // Operation select
    input wire cpu_core_pkg::alu_func_t i_func,
    // Operands and carry in
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_carry,
    // Result and flags
    output logic [7:0] o_y,
    output logic o_carry,
    output logic o_zero,
    output logic o_write
);
    logic [8:0] sum; // Carry plus result

    // Purely combinational so the whole op fits one clock
    always_comb begin
        sum = 9'h000;
        unique case (i_func)
            cpu_core_pkg::ALU_ADD: sum = {1'b0, i_a} + {1'b0, i_b};
            cpu_core_pkg::ALU_ADC: sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_carry};
            cpu_core_pkg::ALU_SUB,
            cpu_core_pkg::ALU_CP: sum = {1'b0, i_a} - {1'b0, i_b};
            cpu_core_pkg::ALU_SBC,
            cpu_core_pkg::ALU_CPC: sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_carry};
            cpu_core_pkg::ALU_AND: sum = {i_carry, i_a & i_b};
            cpu_core_pkg::ALU_OR: sum = {i_carry, i_a | i_b};
            cpu_core_pkg::ALU_EOR: sum = {i_carry, i_a ^ i_b};
            cpu_core_pkg::ALU_PASS: sum = {i_carry, i_b};
            cpu_core_pkg::ALU_INC: sum = {i_carry, i_a + 8'h01};
            cpu_core_pkg::ALU_DEC: sum = {i_carry, i_a - 8'h01};
            cpu_core_pkg::ALU_COM: sum = {1'b1, ~i_a};
            cpu_core_pkg::ALU_LSR: sum = {i_a[0], 1'b0, i_a[7:1]};
            cpu_core_pkg::ALU_SWAP: sum = {i_carry, i_a[3:0], i_a[7:4]};
            default: sum = {i_carry, i_a}; // Unused code leaves operand intact
        endcase
    end

    assign o_y = sum[7:0];
    assign o_carry = sum[8];
    assign o_zero = (sum[7:0] == 8'h00);
    // Compares only touch flags
    assign o_write = (i_func != cpu_core_pkg::ALU_CP) && (i_func != cpu_core_pkg::ALU_CPC);
endmodule // cpu_alu8

// ===== hw/cpu_core_datapath.sv
// CPU register file, pointers, data space map, fetch pipeline and stack
`timescale 1ns/1ps
module cpu_core_datapath (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Program memory fetch port
    output logic [11:0] o_prog_addr,
    input wire logic [15:0] i_prog_word,
    output logic [15:0] o_instr_word,
    output logic o_instr_valid,
    // Decoded fields of the current instruction
    input wire cpu_core_pkg::op_t i_op,
    input wire cpu_core_pkg::alu_func_t i_alu_func,
    input wire logic [4:0] i_rd,
    input wire logic [4:0] i_rr,
    input wire logic [7:0] i_imm,
    input wire cpu_core_pkg::addr_mode_t i_mode,
    input wire cpu_core_pkg::ptr_sel_t i_ptr,
    input wire logic [5:0] i_disp,
    input wire logic [5:0] i_io_addr,
    input wire logic [11:0] i_rel_k,
    // Constant table port
    output logic [11:0] o_const_addr,
    input wire logic [15:0] i_const_word,
    // Peripheral I/O port
    output logic [5:0] o_io_addr,
    output logic [7:0] o_io_wdata,
    output logic o_io_we,
    output logic o_io_re,
    input wire logic [7:0] i_io_rdata,
    // Interrupt requests and grant
    input wire logic [15:0] i_irq_req,
    output logic [15:0] o_irq_ack,
    // Visible core state
    output logic [9:0] o_stack_ptr,
    output logic [7:0] o_status
);
    logic [7:0] regs [cpu_core_pkg::NUM_REGS]; // Working registers
    logic [7:0] sram [cpu_core_pkg::SRAM_BYTES]; // Internal data SRAM
    cpu_core_pkg::state_t state; // Execute state
    cpu_core_pkg::state_t next_state;
    logic [4:0] wait_rd; // Destination held over an I/O wait
    logic const_hi; // Byte select held over a constant wait

    // Execute qualifiers
    wire exec = (state == cpu_core_pkg::ST_RUN) && o_instr_valid;
    wire irq_any = |i_irq_req;
    wire take_irq = exec && o_status[cpu_core_pkg::STATUS_I] && irq_any;
    wire go = exec && !take_irq;
    wire wait_io = (state == cpu_core_pkg::ST_WAIT_IO);
    wire wait_const = (state == cpu_core_pkg::ST_WAIT_CONST);
    wire is_alu = (i_op == cpu_core_pkg::OP_ALU_RR) || (i_op == cpu_core_pkg::OP_ALU_RK)
        || (i_op == cpu_core_pkg::OP_ALU_R);
    wire is_ld = go && ((i_op == cpu_core_pkg::OP_LD) || (i_op == cpu_core_pkg::OP_IN));
    wire is_st = go && ((i_op == cpu_core_pkg::OP_ST) || (i_op == cpu_core_pkg::OP_OUT));
    wire is_io_op = (i_op == cpu_core_pkg::OP_IN) || (i_op == cpu_core_pkg::OP_OUT);
    wire lpm = go && (i_op == cpu_core_pkg::OP_LPM);
    wire rjmp = go && ((i_op == cpu_core_pkg::OP_RJMP) || (i_op == cpu_core_pkg::OP_RCALL));
    wire ijmp = go && (i_op == cpu_core_pkg::OP_IJMP);
    wire pop = go && ((i_op == cpu_core_pkg::OP_RET) || (i_op == cpu_core_pkg::OP_RETI));
    wire push = take_irq || (go && (i_op == cpu_core_pkg::OP_RCALL));

    // Immediate forms are pinned to the upper half of the file
    wire [4:0] rd_eff = (i_op == cpu_core_pkg::OP_ALU_RK) ?
        (cpu_core_pkg::IMM_REG_BASE | {1'b0, i_rd[3:0]}) : i_rd;
    wire [7:0] op_a = regs[rd_eff];
    // Register-register forms read any source register
    wire [7:0] op_b = (i_op == cpu_core_pkg::OP_ALU_RK) ? i_imm : regs[i_rr];
    wire [7:0] st_src = regs[i_rr]; // Store data comes from the source register i_rr

    // ALU
    wire [7:0] alu_y;
    wire alu_c;
    wire alu_z;
    wire alu_write;
    cpu_alu8 cpu_alu8_i (
        .i_func(i_alu_func),
        .i_a(op_a),
        .i_b(op_b),
        .i_carry(o_status[cpu_core_pkg::STATUS_C]),
        .o_y(alu_y),
        .o_carry(alu_c),
        .o_zero(alu_z),
        .o_write(alu_write)
    );

    // Pointer pairs; displacement mode only offers Y or Z
    wire [4:0] ptr_lo = (i_mode == cpu_core_pkg::AM_DISP) ?
        ((i_ptr == cpu_core_pkg::PTR_Z) ? cpu_core_pkg::PTR_Z_LO : cpu_core_pkg::PTR_Y_LO) :
        (i_ptr == cpu_core_pkg::PTR_Z) ? cpu_core_pkg::PTR_Z_LO :
        (i_ptr == cpu_core_pkg::PTR_Y) ? cpu_core_pkg::PTR_Y_LO : cpu_core_pkg::PTR_X_LO;
    wire [4:0] ptr_hi = ptr_lo + 5'h01;
    wire [15:0] ptr_val = {regs[ptr_hi], regs[ptr_lo]};
    wire [15:0] z_val = {regs[cpu_core_pkg::PTR_Z_LO + 5'h01], regs[cpu_core_pkg::PTR_Z_LO]};
    wire [15:0] ptr_dec = ptr_val - 16'h0001;
    wire [15:0] ptr_inc = ptr_val + 16'h0001;

    // Effective data address; direct mode reads the second word in flight
    logic [15:0] ea;
    always_comb begin
        if (is_io_op) begin
            ea = cpu_core_pkg::IO_BASE + {10'h000, i_io_addr};
        end else begin
            unique case (i_mode)
                cpu_core_pkg::AM_DIRECT: ea = i_prog_word;
                cpu_core_pkg::AM_DISP: ea = ptr_val + {10'h000, i_disp};
                cpu_core_pkg::AM_PREDEC: ea = ptr_dec;
                cpu_core_pkg::AM_POSTINC: ea = ptr_val;
                default: ea = ptr_val;
            endcase
        end
    end
    wire mem_op = (is_ld || is_st) && !is_io_op;
    wire ptr_we = mem_op && ((i_mode == cpu_core_pkg::AM_PREDEC)
        || (i_mode == cpu_core_pkg::AM_POSTINC));
    wire [15:0] ptr_new = (i_mode == cpu_core_pkg::AM_PREDEC) ? ptr_dec : ptr_inc;
    wire two_word = mem_op && (i_mode == cpu_core_pkg::AM_DIRECT);

    // Data space decode
    wire hit_reg = (ea < cpu_core_pkg::REG_END);
    wire hit_io = !hit_reg && (ea < cpu_core_pkg::SRAM_BASE);
    wire hit_sram = (ea >= cpu_core_pkg::SRAM_BASE) && (ea < cpu_core_pkg::SRAM_END);
    wire [15:0] io_rel = ea - cpu_core_pkg::IO_BASE;
    wire [5:0] io_off = io_rel[5:0];
    wire [15:0] sram_rel = ea - cpu_core_pkg::SRAM_BASE;
    wire [8:0] sram_idx = sram_rel[8:0];
    wire io_int = hit_io && ((io_off == cpu_core_pkg::IO_SP_LO)
        || (io_off == cpu_core_pkg::IO_SP_HI) || (io_off == cpu_core_pkg::IO_STATUS));
    wire [7:0] io_int_rdata = (io_off == cpu_core_pkg::IO_SP_LO) ? o_stack_ptr[7:0] :
        (io_off == cpu_core_pkg::IO_SP_HI) ? {6'h00, o_stack_ptr[9:8]} : o_status;
    // Unmapped addresses read as zero
    wire [7:0] map_rdata = hit_reg ? regs[ea[4:0]] : io_int ? io_int_rdata :
        hit_sram ? sram[sram_idx] : 8'h00;

    // Peripheral reads need one wait cycle; internal ones do not
    wire ext_io_rd = is_ld && hit_io && !io_int;
    wire ext_io_wr = is_st && hit_io && !io_int;
    wire stall_start = ext_io_rd || lpm;
    wire io_int_wr = is_st && io_int;

    // Single register write port
    wire alu_wr = go && is_alu && alu_write;
    wire ld_wr = is_ld && !ext_io_rd;
    wire st_reg = is_st && hit_reg;
    wire rf_we = wait_io || wait_const || alu_wr || ld_wr || st_reg;
    wire [7:0] const_byte = const_hi ? i_const_word[15:8] : i_const_word[7:0];
    wire [4:0] rf_widx = wait_io ? wait_rd : wait_const ? 5'h00 :
        st_reg ? ea[4:0] : alu_wr ? rd_eff : i_rd;
    wire [7:0] rf_wdata = wait_io ? i_io_rdata : wait_const ? const_byte :
        st_reg ? st_src : alu_wr ? alu_y : map_rdata;

    // Register file; an explicit write beats the pointer update
    for (genvar i = 0; i < cpu_core_pkg::NUM_REGS; i++) begin : g_reg
        always_ff @(posedge i_sys_clk) begin
            if (rf_we && (rf_widx == 5'(i))) begin
                regs[i] <= rf_wdata;
            end else if (ptr_we && (ptr_lo == 5'(i))) begin
                regs[i] <= ptr_new[7:0];
            end else if (ptr_we && (ptr_hi == 5'(i))) begin
                regs[i] <= ptr_new[15:8];
            end
        end
    end

    // Stack addressing; SP is assumed loaded into SRAM before first push
    wire [15:0] sp_rel = {6'h00, o_stack_ptr} - cpu_core_pkg::SRAM_BASE;
    wire [8:0] push_lo_idx = sp_rel[8:0];
    wire [8:0] push_hi_idx = push_lo_idx - 9'h001;
    wire [8:0] pop_hi_idx = push_lo_idx + 9'h001;
    wire [8:0] pop_lo_idx = push_lo_idx + 9'h002;
    wire [11:0] ret_pc = {sram[pop_hi_idx][3:0], sram[pop_lo_idx]};
    wire [11:0] ret_addr = take_irq ? (o_prog_addr - 12'h001) : o_prog_addr;
    wire st_sram = is_st && hit_sram;

    // SRAM entries; a data store never coincides with a push
    for (genvar j = 0; j < cpu_core_pkg::SRAM_BYTES; j++) begin : g_sram
        always_ff @(posedge i_sys_clk) begin
            if (st_sram && (sram_idx == 9'(j))) begin
                sram[j] <= st_src;
            end else if (push && (push_lo_idx == 9'(j))) begin
                sram[j] <= ret_addr[7:0];
            end else if (push && (push_hi_idx == 9'(j))) begin
                sram[j] <= {4'h0, ret_addr[11:8]};
            end
        end
    end

    // Interrupt priority: lowest request index wins
    logic [3:0] irq_idx;
    always_comb begin
        irq_idx = 4'h0;
        for (int k = cpu_core_pkg::NUM_IRQ - 1; k >= 0; k--) begin
            if (i_irq_req[k]) begin
                irq_idx = 4'(k);
            end
        end
    end
    wire [15:0] irq_onehot = i_irq_req & (~i_irq_req + 16'h0001);
    wire [11:0] irq_vec = {8'h00, irq_idx} + cpu_core_pkg::VEC_FIRST_IRQ;

    // Next fetch address; the counter always points one past the executing word
    wire [11:0] rel_target = o_prog_addr + i_rel_k;
    wire [11:0] next_pc = take_irq ? irq_vec : rjmp ? rel_target :
        ijmp ? z_val[11:0] : pop ? ret_pc :
        stall_start ? o_prog_addr : (o_prog_addr + 12'h001);
    // Taken branches and second words leave a bubble in the pipe
    wire next_valid = stall_start ? o_instr_valid : !(take_irq || rjmp || ijmp || pop || two_word);
    assign next_state = !stall_start ? cpu_core_pkg::ST_RUN :
        lpm ? cpu_core_pkg::ST_WAIT_CONST : cpu_core_pkg::ST_WAIT_IO;

    // Fetch stage runs beside execute
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_prog_addr <= cpu_core_pkg::PC_RESET;
            o_instr_word <= 16'h0000;
            o_instr_valid <= 1'b0;
            state <= cpu_core_pkg::ST_RUN;
        end else begin
            o_prog_addr <= next_pc;
            o_instr_valid <= next_valid;
            state <= next_state;
            if (!stall_start) begin
                o_instr_word <= i_prog_word;
            end
        end
    end

    // Wait-state bookkeeping and constant lookup address
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            wait_rd <= 5'h00;
            const_hi <= 1'b0;
            o_const_addr <= 12'h000;
        end else begin
            if (ext_io_rd) begin
                wait_rd <= i_rd;
            end
            if (lpm) begin
                o_const_addr <= z_val[12:1];
                const_hi <= z_val[0];
            end
        end
    end

    // Peripheral strobes last one cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_io_we <= 1'b0;
            o_io_re <= 1'b0;
            o_io_addr <= 6'h00;
            o_io_wdata <= 8'h00;
        end else begin
            o_io_we <= ext_io_wr;
            o_io_re <= ext_io_rd;
            if (ext_io_wr || ext_io_rd) begin
                o_io_addr <= io_off;
            end
            if (ext_io_wr) begin
                o_io_wdata <= st_src;
            end
        end
    end

    // Stack pointer: push and pop move it by two bytes
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_stack_ptr <= cpu_core_pkg::SP_RESET;
        end else if (push) begin
            o_stack_ptr <= o_stack_ptr - 10'h002;
        end else if (pop) begin
            o_stack_ptr <= o_stack_ptr + 10'h002;
        end else if (io_int_wr && (io_off == cpu_core_pkg::IO_SP_LO)) begin
            o_stack_ptr <= {o_stack_ptr[9:8], st_src};
        end else if (io_int_wr && (io_off == cpu_core_pkg::IO_SP_HI)) begin
            o_stack_ptr <= {st_src[1:0], o_stack_ptr[7:0]};
        end
    end

    // Status flags and global interrupt enable
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_status <= cpu_core_pkg::STATUS_RESET;
            o_irq_ack <= 16'h0000;
        end else begin
            o_irq_ack <= take_irq ? irq_onehot : 16'h0000;
            if (take_irq) begin
                o_status[cpu_core_pkg::STATUS_I] <= 1'b0;
            end else if (go && (i_op == cpu_core_pkg::OP_RETI)) begin
                o_status[cpu_core_pkg::STATUS_I] <= 1'b1;
            end else if (io_int_wr && (io_off == cpu_core_pkg::IO_STATUS)) begin
                o_status <= st_src;
            end else if (go && is_alu) begin
                o_status[cpu_core_pkg::STATUS_C] <= alu_c;
                o_status[cpu_core_pkg::STATUS_Z] <= alu_z;
            end
        end
    end

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    property p_alu_one_cycle;
        alu_wr && (i_op == cpu_core_pkg::OP_ALU_RR) |=> regs[$past(rd_eff)] == $past(alu_y);
    endproperty
    a_alu_one_cycle: assert property (p_alu_one_cycle) else $error("ALU result not written");

    property p_imm_upper;
        alu_wr && (i_op == cpu_core_pkg::OP_ALU_RK) |=> regs[{1'b1, $past(i_rd[3:0])}]
            == $past(alu_y);
    endproperty
    a_imm_upper: assert property (p_imm_upper) else $error("Immediate result not in upper reg");

    property p_store_reg;
        st_reg && !ptr_we |=> regs[$past(rf_widx)] == $past(st_src);
    endproperty
    a_store_reg: assert property (p_store_reg) else $error("Store to reg address lost");

    property p_postinc;
        ptr_we && (i_mode == cpu_core_pkg::AM_POSTINC) && (i_rd < 5'h1A) && !st_reg
            |=> {regs[$past(ptr_hi)], regs[$past(ptr_lo)]} == $past(ptr_inc);
    endproperty
    a_postinc: assert property (p_postinc) else $error("Pointer not incremented");

    property p_io_wait;
        ext_io_rd |=> o_io_re && wait_io && (o_io_addr == $past(io_off)) ##1 !o_io_re && !wait_io;
    endproperty
    a_io_wait: assert property (p_io_wait) else $error("I/O read wait wrong");

    property p_lpm;
        lpm |=> wait_const && (o_const_addr == $past(z_val[12:1])) ##1 state == cpu_core_pkg::ST_RUN;
    endproperty
    a_lpm: assert property (p_lpm) else $error("Constant lookup sequence wrong");

    property p_stream;
        go && (i_op == cpu_core_pkg::OP_NOP) |=> o_instr_valid
            && (o_prog_addr == $past(o_prog_addr) + 12'h001);
    endproperty
    a_stream: assert property (p_stream) else $error("Pipeline did not advance");

    property p_rjmp;
        rjmp |=> !o_instr_valid && (o_prog_addr == $past(rel_target)) ##1 o_instr_valid;
    endproperty
    a_rjmp: assert property (p_rjmp) else $error("Relative jump wrong");

    property p_call_push;
        push |=> o_stack_ptr == $past(o_stack_ptr) - 10'h002;
    endproperty
    a_call_push: assert property (p_call_push) else $error("Stack not pushed");

    property p_irq_vec;
        take_irq |=> (o_prog_addr == $past(irq_vec)) && (o_irq_ack == $past(irq_onehot))
            && !o_status[cpu_core_pkg::STATUS_I];
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("Interrupt vector wrong");

    c_io_read: cover property (ext_io_rd ##2 o_instr_valid);
    c_lpm: cover property (lpm ##1 wait_const);
    c_irq: cover property (take_irq ##2 o_instr_valid);
    c_call_ret: cover property (push ##[2:40] pop);
endmodule // cpu_core_datapath

// ===== testbench/cpu_core_datapath_tb.sv
// Self-checking bench for the CPU register file and data map
`timescale 1ns/1ps
module cpu_core_datapath_tb;
    logic i_sys_clk = 1'b0; // 40 MHz system clock
    logic i_sys_rst = 1'b1; // Synchronous reset, active high
    cpu_core_pkg::op_t i_op = cpu_core_pkg::OP_NOP;
    cpu_core_pkg::alu_func_t i_alu_func = cpu_core_pkg::ALU_PASS;
    cpu_core_pkg::addr_mode_t i_mode = cpu_core_pkg::AM_DIRECT;
    cpu_core_pkg::ptr_sel_t i_ptr = cpu_core_pkg::PTR_Z;
    logic [4:0] i_rd = 5'h00, i_rr = 5'h00;
    logic [7:0] i_imm = 8'h00, i_io_rdata = 8'hC3;
    logic [5:0] i_disp = 6'h00, i_io_addr = 6'h00;
    logic [11:0] i_rel_k = 12'h000;
    logic [15:0] i_prog_word = 16'h0000, i_const_word = 16'hBE5F, i_irq_req = 16'h0000;
    logic [11:0] o_prog_addr, o_const_addr, p;
    logic [15:0] o_instr_word, o_irq_ack;
    logic [5:0] o_io_addr;
    logic [7:0] o_io_wdata, o_status;
    logic [9:0] o_stack_ptr;
    logic o_instr_valid, o_io_we, o_io_re;
    int failures = 0, checked = 0; // Mismatch and comparison counts
    cpu_core_datapath cpu_core_datapath_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .o_prog_addr(o_prog_addr), .i_prog_word(i_prog_word), .o_instr_word(o_instr_word),
        .o_instr_valid(o_instr_valid), .i_op(i_op), .i_alu_func(i_alu_func), .i_rd(i_rd),
        .i_rr(i_rr), .i_imm(i_imm), .i_mode(i_mode), .i_ptr(i_ptr), .i_disp(i_disp),
        .i_io_addr(i_io_addr), .i_rel_k(i_rel_k), .o_const_addr(o_const_addr),
        .i_const_word(i_const_word), .o_io_addr(o_io_addr), .o_io_wdata(o_io_wdata),
        .o_io_we(o_io_we), .o_io_re(o_io_re), .i_io_rdata(i_io_rdata), .i_irq_req(i_irq_req),
        .o_irq_ack(o_irq_ack), .o_stack_ptr(o_stack_ptr), .o_status(o_status));
    // Free-running clock, 25 ns period
    initial begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    // Compare seen against expected; four-state compare so X never matches
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Present one decoded instruction; it executes at the following edge
    task automatic issue(input cpu_core_pkg::op_t op, input cpu_core_pkg::alu_func_t fn,
        input logic [4:0] rd, input logic [4:0] rr, input logic [7:0] imm, input logic [5:0] io);
        @(posedge i_sys_clk);
        i_op <= op;
        i_alu_func <= fn;
        i_rd <= rd;
        i_rr <= rr;
        i_imm <= imm;
        i_io_addr <= io;
    endtask
    // Idle slot, then look once the previous edge has settled
    task automatic nop_look;
        issue(cpu_core_pkg::OP_NOP, cpu_core_pkg::ALU_PASS, 5'h00, 5'h00, 8'h00, 6'h00);
        #1;
    endtask
    // Immediate load; rd is folded into the upper half by the design
    task automatic ldc(input logic [4:0] rd, input logic [7:0] k);
        issue(cpu_core_pkg::OP_ALU_RK, cpu_core_pkg::ALU_PASS, rd, 5'h00, k, 6'h00);
    endtask
    task automatic out_reg(input logic [4:0] rr, input logic [5:0] io);
        issue(cpu_core_pkg::OP_OUT, cpu_core_pkg::ALU_PASS, 5'h00, rr, 8'h00, io);
    endtask
    // Outputs in and just after reset
    task automatic t_reset;
        repeat (5) @(posedge i_sys_clk);
        #1;
        chk(o_prog_addr, 12'h000);
        chk(o_stack_ptr, 10'h000);
        chk(o_instr_valid, 1'b0);
        chk(o_status, 8'h00);
        @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        i_prog_word <= 16'h1234;
        @(posedge i_sys_clk);
        #1;
        chk(o_instr_valid, 1'b1);
        chk(o_prog_addr, 12'h001);
        chk(o_instr_word, 16'h1234);
        $display("test reset done");
    endtask
    // Immediate load, peripheral read, register add, peripheral write
    task automatic t_alu_io;
        ldc(5'h00, 8'h5A);
        issue(cpu_core_pkg::OP_IN, cpu_core_pkg::ALU_PASS, 5'h03, 5'h00, 8'h00, 6'h07);
        nop_look;
        chk(o_io_re, 1'b1);
        chk(o_io_addr, 6'h07);
        issue(cpu_core_pkg::OP_ALU_RR, cpu_core_pkg::ALU_ADD, 5'h10, 5'h03, 8'h00, 6'h00);
        out_reg(5'h10, 6'h05);
        nop_look;
        chk(o_io_we, 1'b1);
        chk(o_io_wdata, 8'h1D);
        chk(o_status[0], 1'b1);
        nop_look;
        chk(o_io_we, 1'b0);
        $display("test alu_io done");
    endtask
    // Constant lookup through the Z pair, odd byte address picks the high byte
    task automatic t_lpm;
        ldc(5'h0E, 8'h03);
        ldc(5'h0F, 8'h00);
        issue(cpu_core_pkg::OP_LPM, cpu_core_pkg::ALU_PASS, 5'h00, 5'h00, 8'h00, 6'h00);
        nop_look;
        chk(o_const_addr, 12'h001);
        out_reg(5'h00, 6'h06);
        nop_look;
        chk(o_io_wdata, 8'hBE);
        $display("test lpm done");
    endtask
    // Stack pointer load through I/O space, then a relative call
    task automatic t_call;
        ldc(5'h01, 8'h5F);
        ldc(5'h02, 8'h02);
        out_reg(5'h11, 6'h3D);
        out_reg(5'h12, 6'h3E);
        nop_look;
        chk(o_stack_ptr, 10'h25F);
        issue(cpu_core_pkg::OP_RCALL, cpu_core_pkg::ALU_PASS, 5'h00, 5'h00, 8'h00, 6'h00);
        i_rel_k <= 12'h010;
        #1;
        p = o_prog_addr;
        nop_look;
        chk(o_prog_addr, p + 12'h010);
        chk(o_stack_ptr, 10'h25D);
        chk(o_instr_valid, 1'b0);
        $display("test call done");
    endtask
    // Enable interrupts through the status byte, then two requests at once
    task automatic t_irq;
        ldc(5'h03, 8'h80);
        out_reg(5'h13, 6'h3F);
        nop_look;
        chk(o_status, 8'h80);
        @(posedge i_sys_clk);
        i_irq_req <= 16'h0006;
        @(posedge i_sys_clk);
        i_irq_req <= 16'h0000;
        #1;
        chk(o_irq_ack, 16'h0002);
        chk(o_prog_addr, 12'h002);
        chk(o_status[7], 1'b0);
        chk(o_stack_ptr, 10'h25B);
        nop_look;
        chk(o_irq_ack, 16'h0000);
        $display("test irq done");
    endtask
    // Store to a register address via X, then load back with post-increment
    task automatic t_store;
        ldc(5'h0A, 8'h05);
        ldc(5'h0B, 8'h00);
        i_ptr <= cpu_core_pkg::PTR_X;
        i_mode <= cpu_core_pkg::AM_IND;
        issue(cpu_core_pkg::OP_ST, cpu_core_pkg::ALU_PASS, 5'h00, 5'h13, 8'h00, 6'h00);
        issue(cpu_core_pkg::OP_LD, cpu_core_pkg::ALU_PASS, 5'h07, 5'h00, 8'h00, 6'h00);
        i_mode <= cpu_core_pkg::AM_POSTINC;
        out_reg(5'h07, 6'h08);
        nop_look;
        chk(o_io_wdata, 8'h80);
        out_reg(5'h1A, 6'h09);
        nop_look;
        chk(o_io_wdata, 8'h06);
        $display("test store done");
    endtask
    // Single place where the run ends
    task automatic give_verdict;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog: the tests need well under 100 cycles
    initial begin
        repeat (2000) @(posedge i_sys_clk);
        failures++;
        give_verdict;
    end
    initial begin
        t_reset;
        t_alu_io;
        t_lpm;
        t_call;
        t_irq;
        t_store;
        give_verdict;
    end
endmodule // cpu_core_datapath_tb
